// file: dv/dcwd_props.sv
// Checker bound to the command word decoder
`default_nettype none
module dcwd_props
  import ctl_word_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic [CW_W-1:0] drive_command_word,
  input  wire logic            word_valid,
  input  wire logic [SET_W-1:0] position_set_selector,
  input  wire logic            fault_pending,
  input  wire logic            fault_cause_gone,
  input  wire drive_cmd_s      cmd,
  input  wire task_opts_s      task_opts,
  input  wire logic            positioning_active,
  input  wire logic            homing_active,
  input  wire logic            jog_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Word taken two edges before the command is sampled
  sequence s_bit(int b);
    $past(word_valid, 2) && $past(drive_command_word[b], 2);
  endsequence
  a_start_needs_bits: assert property (cmd.pos_start |-> positioning_active ##0
    s_bit(BIT_ACTIVATE) ##0 s_bit(BIT_NO_REJECT) ##0 s_bit(BIT_NO_STOP)) else $error("start");
  a_decel_stops: assert property (cmd.pos_decel |-> !positioning_active) else $error("decel");
  a_word_opts: assert property (cmd.pos_start
    && ($past(position_set_selector) == FIELDBUS_SET)
    |-> task_opts.relative == $past(drive_command_word[BIT_RELATIVE], 2)) else $error("opts");
  a_speed_excl: assert property (cmd.speed_enable |-> !cmd.speed_zero) else $error("speed");
  a_fault_cause: assert property (cmd.fault_ack |->
    $past(fault_pending) && $past(fault_cause_gone)) else $error("fault ack");
  a_jog_pos: assert property (cmd.jog_pos_start |-> jog_active ##0 s_bit(BIT_JOG_POS))
    else $error("jog pos");
  a_jog_neg: assert property (cmd.jog_neg_start |-> jog_active ##0 s_bit(BIT_JOG_NEG))
    else $error("jog neg");
  a_plc_gate: assert property ($past(word_valid, 2)
    && !$past(drive_command_word[BIT_BY_PLC], 2)
    |-> !(cmd.pos_start || cmd.jog_pos_start || cmd.homing_start || cmd.fault_ack))
    else $error("gate");
  a_homing_cancel: assert property (cmd.homing_cancel |-> !homing_active)
    else $error("homing");
  a_change_opt: assert property (cmd.pos_queue |-> !task_opts.change_now) else $error("queue");
endmodule
bind drive_control_word_decoder dcwd_props dcwd_props_inst (.mclk(mclk), .rst_n(rst_n),
  .drive_command_word(drive_command_word), .word_valid(word_valid),
  .position_set_selector(position_set_selector),
  .fault_pending(fault_pending), .fault_cause_gone(fault_cause_gone), .cmd(cmd),
  .task_opts(task_opts), .positioning_active(positioning_active),
  .homing_active(homing_active), .jog_active(jog_active));
`default_nettype wire

// file: dv/plc_master.sv
// Cyclic command word source standing in for the PLC
`default_nettype none
module plc_master
  import ctl_word_pkg::*;
(
  input  wire logic            mclk,
  output var  logic [CW_W-1:0] drive_command_word,
  output var  logic            word_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    drive_command_word = CW_RESET;
    word_valid = 1'b0;
  end
  // One word per call, held steady between samples
  task automatic send(input logic [CW_W-1:0] w);
    @(posedge mclk);
    #1;
    drive_command_word = w;
    word_valid = 1'b1;
    @(posedge mclk);
    #1;
    word_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the command word decoder
`default_nettype none
module tb_top
  import ctl_word_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             mclk, rst_n, fault_pending, fault_cause_gone, motion_done, word_valid;
  logic             pos_act, hom_act, jog_act, hom_cfg, evl;
  logic [CW_W-1:0]  word;
  logic [SET_W-1:0] sel, task_set;
  op_mode_e         op_mode;
  task_opts_s       sopts, task_opts;
  drive_cmd_s       cmd;
  int               n_fail = 0;
  int               checked = 0;
  plc_master plc_master_inst (.mclk(mclk), .drive_command_word(word), .word_valid(word_valid));
  drive_control_word_decoder drive_control_word_decoder_inst (.mclk(mclk), .rst_n(rst_n),
    .drive_command_word(word), .word_valid(word_valid), .op_mode(op_mode),
    .position_set_selector(sel), .stored_set_opts(sopts), .fault_pending(fault_pending),
    .fault_cause_gone(fault_cause_gone), .motion_done(motion_done), .cmd(cmd),
    .task_set(task_set), .task_opts(task_opts), .positioning_active(pos_act),
    .homing_active(hom_act), .jog_active(jog_act), .use_homing_config(hom_cfg),
    .evaluating(evl));
  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t decoder output differs", $time);
    end
  endtask
  // Returns just after the edge where the decoded answer lands
  task automatic put(input logic [CW_W-1:0] w);
    plc_master_inst.send(w);
    @(posedge mclk);
    #1;
  endtask
  task automatic t_position();
    put(16'h0430);
    put(16'h3470);
    chk(cmd.pos_start, 1'b1);
    chk(task_opts.relative, 1'b1);
    chk(task_set === FIELDBUS_SET, 1'b1);
    put(16'h3430);
    chk(cmd.pos_decel, 1'b1);
    chk(pos_act, 1'b0);
    put(16'h0460);
    chk(cmd.pos_start, 1'b0);
  endtask
  task automatic t_stored();
    sel = 8'h05;
    sopts = 2'b01;
    put(16'h0430);
    put(16'h3470);
    chk(task_set === 8'h05, 1'b1);
    chk(task_opts.relative, 1'b0);
    put(16'h0430);
    sel = FIELDBUS_SET;
  endtask
  task automatic t_homing();
    put(16'h0C30);
    chk(cmd.homing_start, 1'b1);
    chk(hom_act, 1'b1);
    put(16'h0C70);
    chk(cmd.pos_start, 1'b0);
    chk(hom_cfg, 1'b1);
    put(16'h0430);
    chk(cmd.homing_cancel, 1'b1);
    chk(hom_act, 1'b0);
    put(16'h0C30);
    chk(hom_act, 1'b1);
    motion_done = 1'b1;
    @(posedge mclk);
    #1;
    motion_done = 1'b0;
    chk(hom_act, 1'b0);
  endtask
  task automatic t_speed();
    op_mode = MODE_SPEED;
    put(16'h0440);
    chk(cmd.speed_enable, 1'b1);
    put(16'h0400);
    chk(cmd.speed_zero, 1'b1);
    op_mode = MODE_POSITION;
  endtask
  task automatic t_fault();
    fault_pending = 1'b1;
    put(16'h0480);
    chk(cmd.fault_ack, 1'b0);
    fault_cause_gone = 1'b1;
    put(16'h0400);
    put(16'h0480);
    chk(cmd.fault_ack, 1'b1);
  endtask
  task automatic t_jog();
    for (int b = 8; b < 10; b++) begin
      put(16'h0400);
      put(16'h0400 | (16'h0001 << b));
      chk(b == 8 ? cmd.jog_pos_start : cmd.jog_neg_start, 1'b1);
      chk(jog_act, 1'b1);
      put(16'h0400);
      chk(cmd.jog_decel, 1'b1);
      chk(jog_act, 1'b0);
    end
  endtask
  task automatic t_plc();
    put(16'h0030);
    chk(evl, 1'b0);
    put(16'h0070);
    chk(cmd.pos_start, 1'b0);
    put(16'h0430);
    chk(evl, 1'b1);
    put(16'h0470);
    chk(cmd.pos_start, 1'b1);
    put(16'h0070);
    chk(pos_act, 1'b0);
  endtask
  task automatic test_done();
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    rst_n = 1'b0;
    op_mode = MODE_POSITION;
    sel = FIELDBUS_SET;
    sopts = 2'b00;
    fault_pending = 1'b0;
    fault_cause_gone = 1'b0;
    motion_done = 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    t_position();
    t_stored();
    t_homing();
    t_speed();
    t_fault();
    t_jog();
    t_plc();
    test_done();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire

// file: hdl/cw_edge_detect.sv
// Registers the control word and flags per-bit rising and falling edges
`default_nettype none
module cw_edge_detect
  import ctl_word_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic            sample,
  input  wire logic [CW_W-1:0] word_in,
  output logic      [CW_W-1:0] word_now,
  output logic      [CW_W-1:0] rise,
  output logic      [CW_W-1:0] fall
);
  logic [CW_W-1:0] word_prev;

  // Edges only exist between two accepted samples
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      word_now  <= CW_RESET;
      word_prev <= CW_RESET;
    end else if (sample) begin
      word_prev <= word_now;   // [R16]
      word_now  <= word_in;    // [R16]
    end
  end

  assign rise = word_now & ~word_prev;
  assign fall = ~word_now & word_prev;
endmodule
`default_nettype wire

// file: hdl/drive_control_word_decoder.sv
// Decoder for bits 4 to 13 of the cyclic drive command word
//
// What this block does
// [R01] Activate rising edge starts positioning only with bits 4, 5 set, no homing.
// [R02] Activate high keeps positioning permitted; low keeps it stopped.
// [R03] Activate falling edge interrupts positioning and decelerates to zero.
// [R04] Traversing task takes the position set chosen by the set selector.
// [R05] Fieldbus set uses word options; other sets use their stored options.
// [R06] Speed mode: activate enables setpoint; disabled forces setpoints to zero.
// [R07] Fault reset acknowledges only errors whose cause is already gone.
// [R08] Jog positive: rising starts, high keeps moving, falling decelerates.
// [R09] Jog negative: rising starts, high keeps active, falling decelerates.
// [R10] Word is evaluated only while control-by-PLC bit is one.
// [R11] Homing bit rising starts homing; falling during run cancels, no error.
// [R12] Homing run applies the previously configured homing options.
// [R13] Positioning start: relative bit zero absolute, one relative.
// [R14] Positioning start with change bit zero queues after current task.
// [R15] Positioning start with change bit one aborts current, starts new.
// [R16] Word registered on each word_valid cycle; edges from comparison with previous sample.
`default_nettype none
module drive_control_word_decoder
  import ctl_word_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [CW_W-1:0]  drive_command_word,
  input  wire logic             word_valid,
  input  wire op_mode_e         op_mode,
  input  wire logic [SET_W-1:0] position_set_selector,
  input  wire task_opts_s       stored_set_opts,
  input  wire logic             fault_pending,
  input  wire logic             fault_cause_gone,
  input  wire logic             motion_done,
  output drive_cmd_s            cmd,
  output logic [SET_W-1:0]      task_set,
  output task_opts_s            task_opts,
  output logic                  positioning_active,
  output logic                  homing_active,
  output logic                  jog_active,
  output logic                  use_homing_config,
  output logic                  evaluating
);
  logic [CW_W-1:0] cw;
  logic [CW_W-1:0] rise;
  logic [CW_W-1:0] fall;
  motion_e         motion;
  motion_e         next_motion;

  cw_edge_detect u_edges (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .sample   (word_valid),
    .word_in  (drive_command_word),
    .word_now (cw),
    .rise     (rise),
    .fall     (fall)
  );

  function automatic logic edge_ok(input logic [CW_W-1:0] v, input int idx);
    edge_ok = v[idx];
  endfunction

  // Evaluation gate; edges are only seen after a fresh sample
  wire by_plc     = cw[BIT_BY_PLC];                                     // [R10]
  logic evaluating_d;
  wire new_sample = evaluating_d;
  wire ev         = by_plc && new_sample;                               // [R10]
  wire pos_mode   = (op_mode == MODE_POSITION);
  wire spd_mode   = (op_mode == MODE_SPEED);

  wire act_rise   = ev && edge_ok(rise, BIT_ACTIVATE);
  wire act_fall   = ev && edge_ok(fall, BIT_ACTIVATE);
  wire act_level  = by_plc && cw[BIT_ACTIVATE];
  wire homing_on  = (motion == MOT_HOMING);

  wire pos_go     = pos_mode && act_rise && cw[BIT_NO_REJECT]
                    && cw[BIT_NO_STOP] && !homing_on;                   // [R01]
  wire pos_stop   = pos_mode && (act_fall || !act_level)
                    && (motion == MOT_POSITION);                        // [R02] [R03]
  wire fb_set     = (position_set_selector == FIELDBUS_SET);            // [R05]
  wire rel_sel    = fb_set ? cw[BIT_RELATIVE] : stored_set_opts.relative;   // [R05] [R13]
  wire chg_sel    = fb_set ? cw[BIT_CHANGE] : stored_set_opts.change_now;   // [R05]
  wire busy_pos   = (motion == MOT_POSITION);
  wire go_queue   = pos_go && busy_pos && !chg_sel;                     // [R14]
  wire go_abort   = pos_go && busy_pos && chg_sel;                      // [R15]

  wire spd_en     = spd_mode && act_level;                              // [R06]
  wire ack        = ev && edge_ok(rise, BIT_FAULT_ACK)
                    && fault_pending && fault_cause_gone;               // [R07]

  wire jp_rise    = ev && edge_ok(rise, BIT_JOG_POS);
  wire jp_fall    = ev && edge_ok(fall, BIT_JOG_POS);
  wire jn_rise    = ev && edge_ok(rise, BIT_JOG_NEG);
  wire jn_fall    = ev && edge_ok(fall, BIT_JOG_NEG);
  wire hm_rise    = ev && edge_ok(rise, BIT_HOMING);
  wire hm_fall    = ev && edge_ok(fall, BIT_HOMING);

  wire motion_idle = (motion == MOT_IDLE);
  wire jp_go      = jp_rise && motion_idle;                             // [R08]
  wire jn_go      = jn_rise && motion_idle && !jp_go;                   // [R09]
  wire hm_go      = hm_rise && motion_idle && !jp_go && !jn_go;         // [R11]
  wire jp_stop    = (motion == MOT_JOG_POS) && (jp_fall || !(by_plc && cw[BIT_JOG_POS])); // [R08]
  wire jn_stop    = (motion == MOT_JOG_NEG) && (jn_fall || !(by_plc && cw[BIT_JOG_NEG])); // [R09]
  wire hm_cancel  = homing_on && hm_fall;                               // [R11]
  wire pos_begin  = pos_go && (motion_idle || busy_pos) && !jp_go && !jn_go && !hm_go;

  always_comb begin
    next_motion = motion;
    case (motion)
      MOT_IDLE: begin
        if (jp_go) begin
          next_motion = MOT_JOG_POS;
        end else if (jn_go) begin
          next_motion = MOT_JOG_NEG;
        end else if (hm_go) begin
          next_motion = MOT_HOMING;
        end else if (pos_begin) begin
          next_motion = MOT_POSITION;
        end
      end
      MOT_POSITION: begin
        if (pos_stop || (motion_done && !pos_begin)) begin
          next_motion = MOT_IDLE;
        end
      end
      MOT_JOG_POS: begin
        if (jp_stop) begin
          next_motion = MOT_IDLE;
        end
      end
      MOT_JOG_NEG: begin
        if (jn_stop) begin
          next_motion = MOT_IDLE;
        end
      end
      MOT_HOMING: begin
        if (hm_cancel || motion_done) begin
          next_motion = MOT_IDLE;
        end
      end
      default: next_motion = MOT_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      evaluating_d <= 1'b0;
    end else begin
      evaluating_d <= word_valid;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      motion <= MOT_IDLE;
    end else begin
      motion <= next_motion;
    end
  end

  // Command pulses: one cycle, registered; speed_enable and speed_zero are held levels
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmd <= '0;
    end else begin
      cmd.pos_start       <= pos_begin && !busy_pos;                    // [R01]
      cmd.pos_queue       <= go_queue && !pos_stop;                     // [R14]
      cmd.pos_abort_start <= go_abort && !pos_stop;                     // [R15]
      cmd.pos_decel       <= pos_stop;                                  // [R03]
      cmd.speed_enable    <= spd_en;                                    // [R06]
      cmd.speed_zero      <= spd_mode && !spd_en;                       // [R06]
      cmd.fault_ack       <= ack;                                       // [R07]
      cmd.jog_pos_start   <= jp_go;                                     // [R08]
      cmd.jog_neg_start   <= jn_go;                                     // [R09]
      cmd.jog_decel       <= jp_stop || jn_stop;                        // [R08] [R09]
      cmd.homing_start    <= hm_go;                                     // [R11]
      cmd.homing_cancel   <= hm_cancel;                                 // [R11]
    end
  end

  // Task parameters latch at every positioning start, queued or aborting starts during a run included
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      task_set  <= SET_RESET;
      task_opts <= '0;
    end else if (pos_begin) begin
      task_set           <= position_set_selector;                      // [R04]
      task_opts.relative <= rel_sel;                                    // [R13]
      task_opts.change_now <= chg_sel;                                  // [R14] [R15]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      positioning_active <= 1'b0;
      homing_active      <= 1'b0;
      jog_active         <= 1'b0;
      use_homing_config  <= 1'b0;
      evaluating         <= 1'b0;
    end else begin
      positioning_active <= (next_motion == MOT_POSITION);              // [R02]
      homing_active      <= (next_motion == MOT_HOMING);
      jog_active         <= (next_motion == MOT_JOG_POS) || (next_motion == MOT_JOG_NEG);
      use_homing_config  <= (next_motion == MOT_HOMING);                // [R12]
      evaluating         <= by_plc;                                     // [R10]
    end
  end
endmodule
`default_nettype wire

// file: shared/ctl_word_pkg.sv
// Package: control word bit positions, modes, motion command struct
`default_nettype none
package ctl_word_pkg;
  localparam int CW_W          = 16;
  localparam int BIT_NO_REJECT = 4;
  localparam int BIT_NO_STOP   = 5;
  localparam int BIT_ACTIVATE  = 6;
  localparam int BIT_FAULT_ACK = 7;
  localparam int BIT_JOG_POS   = 8;
  localparam int BIT_JOG_NEG   = 9;
  localparam int BIT_BY_PLC    = 10;
  localparam int BIT_HOMING    = 11;
  localparam int BIT_RELATIVE  = 12;
  localparam int BIT_CHANGE    = 13;

  localparam logic [CW_W-1:0] CW_RESET  = 16'h0000;
  localparam int              SET_W     = 8;
  localparam logic [SET_W-1:0] FIELDBUS_SET = 8'h00;
  localparam logic [SET_W-1:0] SET_RESET    = 8'h00;

  typedef enum logic [1:0] {
    MODE_POSITION = 2'h0,
    MODE_SPEED    = 2'h1,
    MODE_OTHER    = 2'h2
  } op_mode_e;

  typedef enum {
    MOT_IDLE,
    MOT_POSITION,
    MOT_JOG_POS,
    MOT_JOG_NEG,
    MOT_HOMING
  } motion_e;

  // Options that accompany a started positioning
  typedef struct packed {
    logic relative;
    logic change_now;
  } task_opts_s;

  // Commands sent to the motion core, one per line
  typedef struct packed {
    logic       pos_start;
    logic       pos_queue;
    logic       pos_abort_start;
    logic       pos_decel;
    logic       speed_enable;
    logic       speed_zero;
    logic       fault_ack;
    logic       jog_pos_start;
    logic       jog_neg_start;
    logic       jog_decel;
    logic       homing_start;
    logic       homing_cancel;
  } drive_cmd_s;
endpackage
`default_nettype wire
